//--- hw/rlc_pkg.sv
package rlc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  // Least time of steady activity before waking
  localparam int unsigned WAKE_FILTER_NS   = 80;
  localparam int unsigned WAKE_FILTER_CYC  =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least time without activity before standby
  localparam int unsigned IDLE_TIMEOUT_NS  = 2000;
  localparam int unsigned IDLE_TIMEOUT_CYC =
    (IDLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Link clock frequency gate time (longest, rounds down)
  localparam int unsigned FREQ_WINDOW_NS   = 10000;
  localparam int unsigned FREQ_WINDOW_CYC  =
    FREQ_WINDOW_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Field values
  // ---------------------------------------------------------------
  localparam int unsigned LANES             = 3;
  localparam logic        EQ_BYPASS_ON      = 1'h1;
  localparam logic [1:0]  DC_GAIN_BYPASS    = 2'h2;
  localparam logic [3:0]  EQ_ZERO           = 4'h0;
  localparam logic [1:0]  TERM_CODE_NONE    = 2'h0;
  localparam logic [1:0]  TERM_CODE_300     = 2'h1;
  localparam logic [1:0]  TERM_CODE_AUTO    = 2'h2;
  localparam logic [1:0]  TERM_CODE_100     = 2'h3;
  localparam logic        STANDBY_DIS_RST   = 1'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TERM_OPEN,
    TERM_PAR300,
    TERM_PAR100,
    TERM_SUP150,
    TERM_SUP50
  } rlc_term_t;

  typedef enum logic {
    ST_STANDBY,
    ST_ACTIVE
  } rlc_state_t;

  // Strap pins, sampled asynchronously
  typedef struct packed {
    logic i2c_mode;
    logic coupling_strap_pin;
    logic control_strap_zero;
    logic config_strap_zero;
  } rlc_strap_t;

  // Settings written over the serial control port
  typedef struct packed {
    logic                  eq_bypass_enable;
    logic [1:0]            global_dc_gain_select;
    logic [LANES-1:0][3:0] lane_eq_setting;
    logic                  standby_disable;
    logic                  swap;
    logic                  coupling_select_bit;
    logic [1:0]            term_code;
    logic                  legacy_auto_termination;
  } rlc_i2c_cfg_t;

  // Lane control toward the analog front end
  typedef struct packed {
    logic             buffer_mode;
    logic [LANES-1:0] lane_bypass;
    logic             outputs_hiz;
    logic             ac_bias;
    rlc_term_t        term;
  } rlc_lane_ctrl_t;

endpackage

//--- hw/rlc_sync.sv
`timescale 1ns/1ns
module rlc_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // Asynchronous inputs and their settled copy
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } rlc_sync_st_t;

  rlc_sync_st_t st_reg;
  rlc_sync_st_t st_next;

  if (W < 1) begin : g_chk
    $error("rlc_sync: W must be at least 1");
  end

  // Three stages; a bit changes once stages two and three agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.stable[i] = st_reg.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.stable;

endmodule

//--- hw/rlc_lane_ctrl.sv
// What this block does
// - Bypass active passes signals as plain buffer
// - Pin-strap mode keeps bypass always off
// - Serial mode bypass needs enable 1, gain 2
// - Only lanes with zero equalizer are bypassed
// - Standby watches clock or lane two, wakes
// - No activity returns device to standby
// - Standby puts all outputs high impedance
// - Standby enabled by default in both modes
// - Coupling from strap pin or serial bit
// - AC coupling biases outputs internally
// - DC coupling applies no internal bias
// - Config strap zero picks open or 300
// - Control strap high: frequency picks open/300
// - Serial auto-termination bit governs legacy choice
// - Serial DC codes: none, 300, auto, 100
// - Auto code legacy: fixed 300 or frequency
// - AC codes give 150 or 50 to supply
// - Strap DC legacy: none or 300 by strap
// - Strap DC high rate: 100 parallel
`timescale 1ns/1ns
module rlc_lane_ctrl #(
  parameter int unsigned OPEN_LIMIT_EDGES    = 80,
  parameter int unsigned TERM300_LIMIT_EDGES = 110
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  // Straps and serial settings
  input  wire rlc_pkg::rlc_strap_t     strap_i,
  input  wire rlc_pkg::rlc_i2c_cfg_t   cfg_i,
  input  wire logic                    hdmi_high_rate_i,
  // Link clock and activity detectors
  input  wire logic                    link_clk_i,
  input  wire logic                    clk_lane_detect_i,
  input  wire logic                    data_lane2_input_i,
  // Lane control and status
  output rlc_pkg::rlc_lane_ctrl_t      ctrl_o,
  output logic                         standby_o,
  output logic                         legacy_term300_o
);

  // ---------------------------------------------------------------
  // Local sizes and checks
  // ---------------------------------------------------------------
  localparam int unsigned WAKE_W = $clog2(rlc_pkg::WAKE_FILTER_CYC + 1);
  localparam int unsigned IDLE_W = $clog2(rlc_pkg::IDLE_TIMEOUT_CYC + 1);
  localparam int unsigned WIN_W  = $clog2(rlc_pkg::FREQ_WINDOW_CYC + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST =
    WAKE_W'(rlc_pkg::WAKE_FILTER_CYC - 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST =
    IDLE_W'(rlc_pkg::IDLE_TIMEOUT_CYC - 1);
  localparam logic [WIN_W-1:0]  WIN_LAST  =
    WIN_W'(rlc_pkg::FREQ_WINDOW_CYC - 1);
  localparam logic [WIN_W-1:0]  OPEN_LIM  = WIN_W'(OPEN_LIMIT_EDGES);
  localparam logic [WIN_W-1:0]  T300_LIM  = WIN_W'(TERM300_LIMIT_EDGES);

  if (OPEN_LIMIT_EDGES >= TERM300_LIMIT_EDGES ||
      TERM300_LIMIT_EDGES > rlc_pkg::FREQ_WINDOW_CYC) begin : g_chk
    $error("rlc_lane_ctrl: thresholds out of order or too large");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rlc_pkg::rlc_state_t     state;
    logic [WAKE_W-1:0]       wake_cnt;
    logic [IDLE_W-1:0]       idle_cnt;
    logic [WIN_W-1:0]        win_cnt;
    logic [WIN_W-1:0]        edge_cnt;
    logic                    link_prev;
    logic                    legacy_300;
    rlc_pkg::rlc_lane_ctrl_t ctrl;
  } rlc_main_st_t;

  rlc_main_st_t        st_reg;
  rlc_main_st_t        st_next;
  rlc_pkg::rlc_strap_t strap_q;
  logic [2:0]          link_q;
  logic                mon_act;
  logic                sb_en;
  logic                ac_sel;
  logic                link_rise;
  logic [WIN_W-1:0]    edge_tot;
  rlc_pkg::rlc_term_t  legacy_freq_term;

  // ---------------------------------------------------------------
  // Input synchronizers
  // ---------------------------------------------------------------
  // Strap pins
  rlc_sync #(
    .W ($bits(rlc_pkg::rlc_strap_t))
  ) u_strap_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i (strap_i),
    .sync_o  (strap_q)
  );

  // Link clock and both activity detectors
  rlc_sync #(
    .W (3)
  ) u_link_sync (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .async_i ({link_clk_i, data_lane2_input_i, clk_lane_detect_i}),
    .sync_o  (link_q)
  );

  // ---------------------------------------------------------------
  // Selections
  // ---------------------------------------------------------------
  // Monitored lane follows swap
  assign mon_act   = cfg_i.swap ? link_q[1] : link_q[0];
  // Standby on unless the host disables it in serial mode
  assign sb_en     = !(strap_q.i2c_mode &&
                       cfg_i.standby_disable);
  // Coupling source
  assign ac_sel    = strap_q.i2c_mode ? cfg_i.coupling_select_bit
                                      : strap_q.coupling_strap_pin;
  assign link_rise = link_q[2] && !st_reg.link_prev;
  assign edge_tot  = st_reg.edge_cnt + WIN_W'(link_rise);
  assign legacy_freq_term = st_reg.legacy_300 ? rlc_pkg::TERM_PAR300
                                              : rlc_pkg::TERM_OPEN;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.link_prev = link_q[2];

    // Link clock frequency with hysteresis
    if (st_reg.win_cnt == WIN_LAST) begin
      st_next.win_cnt  = '0;
      st_next.edge_cnt = '0;
      if (edge_tot <= OPEN_LIM) begin
        st_next.legacy_300 = 1'b0;
      end else if (edge_tot >= T300_LIM) begin
        st_next.legacy_300 = 1'b1;
      end else begin
        st_next.legacy_300 = st_reg.legacy_300;
      end
    end else begin
      st_next.win_cnt  = st_reg.win_cnt + WIN_W'(1);
      st_next.edge_cnt = edge_tot;
    end

    // Standby and signal detect
    case (st_reg.state)
      rlc_pkg::ST_STANDBY: begin
        st_next.idle_cnt = '0;
        if (!sb_en) begin
          st_next.state    = rlc_pkg::ST_ACTIVE;
          st_next.wake_cnt = '0;
        end else if (!mon_act) begin
          st_next.wake_cnt = '0;
        end else if (st_reg.wake_cnt == WAKE_LAST) begin
          st_next.state    = rlc_pkg::ST_ACTIVE;
          st_next.wake_cnt = '0;
        end else begin
          st_next.wake_cnt = st_reg.wake_cnt + WAKE_W'(1);
        end
      end
      rlc_pkg::ST_ACTIVE: begin
        st_next.wake_cnt = '0;
        if (!sb_en || mon_act) begin
          st_next.idle_cnt = '0;
        end else if (st_reg.idle_cnt == IDLE_LAST) begin
          st_next.state    = rlc_pkg::ST_STANDBY;
          st_next.idle_cnt = '0;
        end else begin
          st_next.idle_cnt = st_reg.idle_cnt + IDLE_W'(1);
        end
      end
      default: begin
        st_next.state = rlc_pkg::ST_STANDBY;
      end
    endcase

    // Outputs high impedance while in standby
    st_next.ctrl.outputs_hiz =
      (st_next.state == rlc_pkg::ST_STANDBY);

    // Equalizer bypass
    st_next.ctrl.buffer_mode = strap_q.i2c_mode &&
      (cfg_i.eq_bypass_enable == rlc_pkg::EQ_BYPASS_ON) &&
      (cfg_i.global_dc_gain_select ==
       rlc_pkg::DC_GAIN_BYPASS);
    for (int i = 0; i < rlc_pkg::LANES; i++) begin
      st_next.ctrl.lane_bypass[i] = st_next.ctrl.buffer_mode &&
        (cfg_i.lane_eq_setting[i] ==
         rlc_pkg::EQ_ZERO);
    end

    // Transmitter bias
    st_next.ctrl.ac_bias = ac_sel;

    // Source termination
    if (strap_q.i2c_mode) begin
      if (ac_sel) begin
        case (cfg_i.term_code)
          rlc_pkg::TERM_CODE_NONE,
          rlc_pkg::TERM_CODE_300: begin
            st_next.ctrl.term = rlc_pkg::TERM_SUP150;
          end
          rlc_pkg::TERM_CODE_AUTO: begin
            st_next.ctrl.term = hdmi_high_rate_i ?
              rlc_pkg::TERM_SUP50 : rlc_pkg::TERM_SUP150;
          end
          default: begin
            st_next.ctrl.term = rlc_pkg::TERM_SUP50;
          end
        endcase
      end else begin
        case (cfg_i.term_code)
          rlc_pkg::TERM_CODE_NONE: begin
            st_next.ctrl.term = rlc_pkg::TERM_OPEN;
          end
          rlc_pkg::TERM_CODE_300: begin
            st_next.ctrl.term = rlc_pkg::TERM_PAR300;
          end
          rlc_pkg::TERM_CODE_AUTO: begin
            if (hdmi_high_rate_i) begin
              st_next.ctrl.term = rlc_pkg::TERM_PAR100;
            end else if (cfg_i.legacy_auto_termination) begin
              st_next.ctrl.term = rlc_pkg::TERM_PAR300;
            end else begin
              st_next.ctrl.term = legacy_freq_term;
            end
          end
          default: begin
            st_next.ctrl.term = rlc_pkg::TERM_PAR100;
          end
        endcase
      end
    end else if (ac_sel) begin
      st_next.ctrl.term = hdmi_high_rate_i ?
        rlc_pkg::TERM_SUP50 : rlc_pkg::TERM_SUP150;
    end else if (hdmi_high_rate_i) begin
      st_next.ctrl.term = rlc_pkg::TERM_PAR100;
    end else if (strap_q.control_strap_zero) begin
      st_next.ctrl.term = strap_q.config_strap_zero ?
        rlc_pkg::TERM_PAR300 : rlc_pkg::TERM_OPEN;
    end else begin
      st_next.ctrl.term = legacy_freq_term;
    end
  end

  // State register; standby after reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg                  <= '0;
      st_reg.state            <= rlc_pkg::ST_STANDBY;
      st_reg.ctrl.outputs_hiz <= 1'b1;
      st_reg.ctrl.term        <= rlc_pkg::TERM_OPEN;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign ctrl_o           = st_reg.ctrl;
  assign standby_o        = (st_reg.state == rlc_pkg::ST_STANDBY);
  assign legacy_term300_o = st_reg.legacy_300;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_bypass_pin_off: assert property (
    !strap_q.i2c_mode |=> !ctrl_o.buffer_mode)
    else $error("bypass active in strap mode");

  a_bypass_cause: assert property (
    $rose(ctrl_o.buffer_mode) |-> $past(strap_q.i2c_mode &&
      cfg_i.eq_bypass_enable && cfg_i.global_dc_gain_select == 2'h2))
    else $error("bypass without its settings");

  a_lane_bypass_eq: assert property (
    ctrl_o.lane_bypass[0] |-> ctrl_o.buffer_mode &&
      $past(cfg_i.lane_eq_setting[0]) == 4'h0)
    else $error("lane bypassed with nonzero eq");

  a_wake_after_filter: assert property (
    (standby_o && !mon_act) ##1 (mon_act && sb_en)[*8] |=> !standby_o)
    else $error("no wake after steady activity");

  a_glitch_no_wake: assert property (
    (standby_o && sb_en && !mon_act) ##1 (mon_act && sb_en)[*3] ##1
      !mon_act |=> standby_o)
    else $error("glitch woke the device");

  a_idle_sleep: assert property (
    (!standby_o && sb_en && !mon_act && st_reg.idle_cnt == IDLE_LAST)
      |=> standby_o)
    else $error("no standby after idle timeout");

  a_hiz_standby: assert property (
    $rose(standby_o) |-> ctrl_o.outputs_hiz ##1 (ctrl_o.outputs_hiz ||
      !standby_o))
    else $error("outputs driven in standby");

  a_standby_off: assert property (
    (strap_q.i2c_mode && cfg_i.standby_disable)[*2] |-> !standby_o)
    else $error("standby while disabled");

  a_coupling_src: assert property (
    ##1 ctrl_o.ac_bias == $past(strap_q.i2c_mode ?
      cfg_i.coupling_select_bit : strap_q.coupling_strap_pin))
    else $error("bias from wrong source");

  a_high_rate_100: assert property (
    hdmi_high_rate_i && !ac_sel && (!strap_q.i2c_mode ||
      cfg_i.term_code == 2'h2) |=> ctrl_o.term == rlc_pkg::TERM_PAR100)
    else $error("high rate not 100 ohm");

  a_serial_dc_300: assert property (
    strap_q.i2c_mode && !cfg_i.coupling_select_bit &&
      cfg_i.term_code == rlc_pkg::TERM_CODE_300
      |=> ctrl_o.term == rlc_pkg::TERM_PAR300)
    else $error("serial code 01 not 300 ohm");

  a_ac_term_50: assert property (
    strap_q.i2c_mode && cfg_i.coupling_select_bit &&
      cfg_i.term_code == rlc_pkg::TERM_CODE_100
      |=> ctrl_o.term == rlc_pkg::TERM_SUP50)
    else $error("AC code 11 not 50 ohm");

  a_strap_cfg_term: assert property (
    !strap_q.i2c_mode && !strap_q.coupling_strap_pin &&
      !hdmi_high_rate_i && strap_q.control_strap_zero &&
      strap_q.config_strap_zero |=> ctrl_o.term == rlc_pkg::TERM_PAR300)
    else $error("strap did not select 300 ohm");

  a_term_hold: assert property (
    st_reg.win_cnt == WIN_LAST && edge_tot > OPEN_LIM &&
      edge_tot < T300_LIM |=> $stable(legacy_term300_o))
    else $error("hysteresis choice changed");

  c_wake:        cover property ($fell(standby_o));
  c_sleep:       cover property ($rose(standby_o));
  c_buffer_mode: cover property ($rose(ctrl_o.buffer_mode));
  c_term300:     cover property ($rose(legacy_term300_o));

endmodule

//--- testbench/rlc_src_model.sv
`timescale 1ns/1ns
module rlc_src_model #(
  parameter int unsigned HALF_NS = 40
) (
  // Commands from the bench
  input  wire logic frame_i,
  input  wire logic clk_act_i,
  input  wire logic d2_act_i,
  // Lines toward the redriver
  output logic      link_clk_o,
  output logic      clk_lane_o,
  output logic      lane2_o
);
  // -------------------------------------------------------------
  // Link clock, parked low between frames, phase off the core clock
  // -------------------------------------------------------------
  initial begin
    link_clk_o = 1'b0;
    #3;
    forever begin
      #HALF_NS;
      link_clk_o = frame_i ? ~link_clk_o : 1'b0;
    end
  end

  // Activity levels of the two lanes that may be watched
  assign clk_lane_o = clk_act_i;
  assign lane2_o    = d2_act_i;
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic                    clk_i;
  logic                    srst_i;
  rlc_pkg::rlc_strap_t     strap;
  rlc_pkg::rlc_i2c_cfg_t   cfg;
  rlc_pkg::rlc_lane_ctrl_t ctrl;
  logic                    high_rate;
  logic                    frame;
  logic                    clk_act;
  logic                    d2_act;
  logic                    link_clk;
  logic                    clk_lane;
  logic                    lane2;
  logic                    standby;
  logic                    term300;
  int                      cyc;
  int                      num_errors;
  int                      n_compared;

  // Clock and cycle count since reset release
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= srst_i ? 0 : cyc + 1;

  // Far side and block under test
  rlc_src_model src (
    .frame_i   (frame),
    .clk_act_i (clk_act),
    .d2_act_i  (d2_act),
    .link_clk_o(link_clk),
    .clk_lane_o(clk_lane),
    .lane2_o   (lane2)
  );
  rlc_lane_ctrl #(
    .OPEN_LIMIT_EDGES   (80),
    .TERM300_LIMIT_EDGES(110)
  ) dut (
    .clk_i             (clk_i),
    .srst_i            (srst_i),
    .strap_i           (strap),
    .cfg_i             (cfg),
    .hdmi_high_rate_i  (high_rate),
    .link_clk_i        (link_clk),
    .clk_lane_detect_i (clk_lane),
    .data_lane2_input_i(lane2),
    .ctrl_o            (ctrl),
    .standby_o         (standby),
    .legacy_term300_o  (term300)
  );

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_mod(input int m);
    while (cyc % 1000 != m) tick(1);
  endtask

  task automatic wait_sb(input logic v, input int lim);
    int k;
    k = 0;
    while (standby !== v && k < lim) begin
      tick(1);
      k++;
    end
  endtask

  task automatic chk_v(input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_term(input rlc_pkg::rlc_term_t e,
                          input rlc_pkg::rlc_term_t g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Expected serial-mode termination with fixed legacy choice
  function automatic rlc_pkg::rlc_term_t exp_term(input logic ac,
      input logic [1:0] c, input logic hr);
    if (ac) begin
      if (c == 2'h3 || (c == 2'h2 && hr)) return rlc_pkg::TERM_SUP50;
      return rlc_pkg::TERM_SUP150;
    end
    if (c == 2'h0) return rlc_pkg::TERM_OPEN;
    if (c == 2'h1) return rlc_pkg::TERM_PAR300;
    if (c == 2'h3 || hr) return rlc_pkg::TERM_PAR100;
    return rlc_pkg::TERM_PAR300;
  endfunction

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_bypass();
    cfg.eq_bypass_enable      = 1'h1;
    cfg.global_dc_gain_select = 2'h2;
    cfg.lane_eq_setting       = {4'h0, 4'h5, 4'h0};
    tick(8);
    chk_v(4'h0, 4'(ctrl.buffer_mode));
    chk_v(4'h0, 4'(ctrl.lane_bypass));
    strap.i2c_mode = 1'b1;
    tick(8);
    chk_v(4'h1, 4'(ctrl.buffer_mode));
    chk_v(4'h5, 4'(ctrl.lane_bypass));
    cfg.global_dc_gain_select = 2'h1;
    tick(2);
    chk_v(4'h0, 4'(ctrl.lane_bypass));
    cfg.global_dc_gain_select = 2'h2;
    cfg.eq_bypass_enable      = 1'h0;
    tick(2);
    chk_v(4'h0, 4'(ctrl.buffer_mode));
    $display("bypass done");
  endtask

  task automatic t_wake();
    clk_act = 1'b1;
    wait_sb(1'b0, 20);
    chk_v(4'h0, 4'(standby));
    chk_v(4'h0, 4'(ctrl.outputs_hiz));
    clk_act = 1'b0;
    wait_sb(1'b1, 230);
    chk_v(4'h1, 4'(ctrl.outputs_hiz));
    clk_act = 1'b1;
    tick(3);
    clk_act = 1'b0;
    tick(20);
    chk_v(4'h1, 4'(standby));
    cfg.swap = 1'b1;
    clk_act  = 1'b1;
    tick(20);
    chk_v(4'h1, 4'(standby));
    d2_act = 1'b1;
    wait_sb(1'b0, 20);
    chk_v(4'h0, 4'(standby));
    d2_act  = 1'b0;
    clk_act = 1'b0;
    cfg.swap = 1'b0;
    wait_sb(1'b1, 230);
    chk_v(4'h1, 4'(standby));
    cfg.standby_disable = 1'b1;
    tick(3);
    chk_v(4'h0, 4'(standby));
    tick(300);
    chk_v(4'h0, 4'(ctrl.outputs_hiz));
    cfg.standby_disable = 1'b0;
    wait_sb(1'b1, 230);
    chk_v(4'h1, 4'(standby));
    $display("standby done");
  endtask

  task automatic t_codes();
    strap.i2c_mode = 1'b0;
    strap.coupling_strap_pin = 1'b1;
    tick(8);
    chk_v(4'h1, 4'(ctrl.ac_bias));
    chk_term(rlc_pkg::TERM_SUP150, ctrl.term);
    strap.coupling_strap_pin = 1'b0;
    tick(8);
    chk_v(4'h0, 4'(ctrl.ac_bias));
    strap.i2c_mode = 1'b1;
    cfg.legacy_auto_termination = 1'b1;
    tick(8);
    for (int i = 0; i < 16; i++) begin
      cfg.coupling_select_bit = i[3];
      cfg.term_code           = i[2:1];
      high_rate               = i[0];
      tick(2);
      chk_v({3'h0, i[3]}, ctrl.ac_bias);
      chk_term(exp_term(i[3], i[2:1], i[0]), ctrl.term);
    end
    $display("codes done");
  endtask

  task automatic t_freq();
    cfg.coupling_select_bit     = 1'b0;
    cfg.term_code               = 2'h2;
    cfg.legacy_auto_termination = 1'b0;
    high_rate = 1'b0;
    frame     = 1'b1;
    tick(2100);
    chk_term(rlc_pkg::TERM_PAR300, ctrl.term);
    for (int h = 0; h < 2; h++) begin
      wait_mod(780);
      frame = 1'b0;
      wait_mod(20);
      frame = 1'b1;
      wait_mod(780);
      frame = 1'b0;
      wait_mod(50);
      chk_v({3'h0, ~h[0]}, term300);
      tick(2100);
      chk_v(4'h0, 4'(term300));
    end
    chk_term(rlc_pkg::TERM_OPEN, ctrl.term);
    strap.i2c_mode = 1'b0;
    tick(8);
    chk_term(rlc_pkg::TERM_OPEN, ctrl.term);
    frame = 1'b1;
    tick(2100);
    chk_term(rlc_pkg::TERM_PAR300, ctrl.term);
    high_rate = 1'b1;
    tick(2);
    chk_term(rlc_pkg::TERM_PAR100, ctrl.term);
    high_rate = 1'b0;
    strap.control_strap_zero = 1'b1;
    tick(8);
    chk_term(rlc_pkg::TERM_OPEN, ctrl.term);
    strap.config_strap_zero = 1'b1;
    tick(8);
    chk_term(rlc_pkg::TERM_PAR300, ctrl.term);
    frame = 1'b0;
    $display("termination done");
  endtask

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    num_errors = 0;
    n_compared = 0;
    srst_i     = 1'b1;
    strap      = '0;
    cfg        = '0;
    high_rate  = 1'b0;
    frame      = 1'b0;
    clk_act    = 1'b0;
    d2_act     = 1'b0;
    tick(8);
    srst_i = 1'b0;
    tick(1);
    chk_v(4'h1, 4'(standby));
    chk_v(4'h1, 4'(ctrl.outputs_hiz));
    chk_v(4'h0, 4'(ctrl.ac_bias));
    chk_term(rlc_pkg::TERM_OPEN, ctrl.term);
    t_bypass();
    t_wake();
    t_codes();
    t_freq();
    print_verdict();
  end

  initial begin
    #300000;
    num_errors++;
    $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
    print_verdict();
  end
endmodule
